/* socr_pkg.sv */
// Package: register map, field layout and reset values of the output configuration bank
package socr_pkg;

    localparam logic [7:0] SOCR_ADDR_DATA_FORMAT = 8'h14;
    localparam logic [7:0] SOCR_ADDR_DRV_TERM = 8'h15;
    localparam logic [7:0] SOCR_ADDR_CLK_PHASE = 8'h16;
    localparam logic [7:0] SOCR_ADDR_PAT1_LO = 8'h19;
    localparam logic [7:0] SOCR_ADDR_PAT1_HI = 8'h1A;
    localparam logic [7:0] SOCR_ADDR_PAT2_LO = 8'h1B;
    localparam logic [7:0] SOCR_ADDR_PAT2_HI = 8'h1C;
    localparam logic [7:0] SOCR_ADDR_TEST_MODE = 8'h0D;

    localparam logic [7:0] SOCR_RST_DATA_FORMAT = 8'h00;
    localparam logic [7:0] SOCR_RST_DRV_TERM = 8'h00;
    localparam logic [7:0] SOCR_RST_CLK_PHASE = 8'h03;
    localparam logic [7:0] SOCR_RST_PATTERN = 8'h00;
    localparam logic [3:0] SOCR_RST_TEST_MODE = 4'h0;

    // Writable bits per register; the rest read zero
    localparam logic [7:0] SOCR_MASK_DATA_FORMAT = 8'h47;
    localparam logic [7:0] SOCR_MASK_DRV_TERM = 8'h30;
    localparam logic [7:0] SOCR_MASK_CLK_PHASE = 8'h0F;

    localparam int SOCR_FMT_LSB = 0;
    localparam int SOCR_FMT_MSB = 1;
    localparam int SOCR_INVERT_BIT = 2;
    localparam int SOCR_LOWSWING_BIT = 6;
    localparam int SOCR_TERM_LSB = 4;
    localparam int SOCR_TERM_MSB = 5;

    localparam logic [1:0] SOCR_FMT_OFFSET_BIN = 2'h0;
    localparam logic [1:0] SOCR_FMT_TWOS_COMP = 2'h1;
    localparam logic [3:0] SOCR_PHASE_MAX = 4'hA;
    localparam logic [3:0] SOCR_TEST_USER = 4'h8;
    localparam logic [3:0] SOCR_TEST_OFF = 4'h0;

    localparam int SOCR_DATA_W = 14;
    localparam int SOCR_PAT_W = 16;

endpackage : socr_pkg

/* socr_output_config.sv */
// Output configuration register bank and the data path it steers
// What this block does
// - Format register resets zero; bits 1:0 format, bit 2 invert, bit 6 low swing
// - Phase register holds four-bit code 0 to 15, codes 0 to 10 legal, resets to code 3
// - Each phase code step moves the output clock another 60 degrees
// - Code 9 puts the clock 540 degrees after the data edge
// - Phase code picks divider phase; sample latching never changes
// - First pattern is 16 bits over two registers, both reset zero
// - Second pattern low byte register resets zero
// - Test mode 8 puts user patterns on outputs instead of samples
// - Second pattern high byte has its own register, reset zero
`timescale 1ns/1ps
module socr_output_config
    import socr_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic SAMPLE_VALID,
    input wire logic [SOCR_DATA_W-1:0] SAMPLE_DATA,
    input wire logic [5:0] DIV_PHASES,
    output logic [SOCR_DATA_W-1:0] OUT_WORD,
    output logic OUT_VALID,
    output logic OUT_LOW_SWING,
    output logic [1:0] OUT_TERM,
    output logic SERIAL_BIT_CLOCK_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] data_format_r;
    logic [7:0] drv_term_r;
    logic [7:0] clk_phase_r;
    logic [7:0] pat1_lo_r;
    logic [7:0] pat1_hi_r;
    logic [7:0] pat2_lo_r;
    logic [7:0] pat2_hi_r;
    logic [3:0] test_mode_r;
    logic pat_sel_r;

    // One strobe per register, so each flop block tests a single bit
    logic wr_format;
    logic wr_term;
    logic wr_phase;
    logic wr_pat1_lo;
    logic wr_pat1_hi;
    logic wr_pat2_lo;
    logic wr_pat2_hi;
    logic wr_test;

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    // an unmapped address raises no strobe, so the write is dropped

    assign wr_format = REG_WR && (REG_ADDR == SOCR_ADDR_DATA_FORMAT);
    assign wr_term = REG_WR && (REG_ADDR == SOCR_ADDR_DRV_TERM);
    assign wr_phase = REG_WR && (REG_ADDR == SOCR_ADDR_CLK_PHASE);
    assign wr_pat1_lo = REG_WR && (REG_ADDR == SOCR_ADDR_PAT1_LO);
    assign wr_pat1_hi = REG_WR && (REG_ADDR == SOCR_ADDR_PAT1_HI);
    assign wr_pat2_lo = REG_WR && (REG_ADDR == SOCR_ADDR_PAT2_LO);
    assign wr_pat2_hi = REG_WR && (REG_ADDR == SOCR_ADDR_PAT2_HI);
    assign wr_test = REG_WR && (REG_ADDR == SOCR_ADDR_TEST_MODE);

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            data_format_r <= SOCR_RST_DATA_FORMAT;
        end else if (wr_format) begin
            data_format_r <= REG_WDATA & SOCR_MASK_DATA_FORMAT;
        end
    end

    // Termination field, bits 5:4 only
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            drv_term_r <= SOCR_RST_DRV_TERM;
        end else if (wr_term) begin
            drv_term_r <= REG_WDATA & SOCR_MASK_DRV_TERM;
        end
    end

    // phase code register, spare bits dropped
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            clk_phase_r <= SOCR_RST_CLK_PHASE;
        end else if (wr_phase) begin
            clk_phase_r <= REG_WDATA & SOCR_MASK_CLK_PHASE;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pat1_lo_r <= SOCR_RST_PATTERN;
        end else if (wr_pat1_lo) begin
            pat1_lo_r <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pat1_hi_r <= SOCR_RST_PATTERN;
        end else if (wr_pat1_hi) begin
            pat1_hi_r <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pat2_lo_r <= SOCR_RST_PATTERN;
        end else if (wr_pat2_lo) begin
            pat2_lo_r <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pat2_hi_r <= SOCR_RST_PATTERN;
        end else if (wr_pat2_hi) begin
            pat2_hi_r <= REG_WDATA;
        end
    end

    // test output mode; only the user pattern code acts here
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            test_mode_r <= SOCR_RST_TEST_MODE;
        end else if (wr_test) begin
            test_mode_r <= REG_WDATA[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read back
    // unmapped addresses and spare bits read zero

    logic [7:0] test_mode_rd;
    assign test_mode_rd = {4'h0, test_mode_r};

    always_comb begin
        case (REG_ADDR)
            SOCR_ADDR_DATA_FORMAT: REG_RDATA = data_format_r;
            SOCR_ADDR_DRV_TERM: REG_RDATA = drv_term_r;
            SOCR_ADDR_CLK_PHASE: REG_RDATA = clk_phase_r;
            SOCR_ADDR_PAT1_LO: REG_RDATA = pat1_lo_r;
            SOCR_ADDR_PAT1_HI: REG_RDATA = pat1_hi_r;
            SOCR_ADDR_PAT2_LO: REG_RDATA = pat2_lo_r;
            SOCR_ADDR_PAT2_HI: REG_RDATA = pat2_hi_r;
            SOCR_ADDR_TEST_MODE: REG_RDATA = test_mode_rd;
            default: REG_RDATA = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Output word path

    logic [SOCR_PAT_W-1:0] pat1_word;
    logic [SOCR_PAT_W-1:0] pat2_word;
    logic [SOCR_PAT_W-1:0] pat_word;
    logic [SOCR_DATA_W-1:0] twos_word;
    logic [SOCR_DATA_W-1:0] fmt_word;
    logic [SOCR_DATA_W-1:0] sel_word;
    logic [SOCR_DATA_W-1:0] word_nxt;
    logic fmt_twos;
    logic invert_on;
    logic user_mode;

    assign fmt_twos = (data_format_r[SOCR_FMT_MSB:SOCR_FMT_LSB] == SOCR_FMT_TWOS_COMP);
    assign invert_on = data_format_r[SOCR_INVERT_BIT];
    assign user_mode = (test_mode_r == SOCR_TEST_USER);
    // Two's complement is offset binary with the sign bit flipped
    assign twos_word = {~SAMPLE_DATA[SOCR_DATA_W-1], SAMPLE_DATA[SOCR_DATA_W-2:0]};

    // byte pairs form the two 16-bit patterns
    assign pat1_word = {pat1_hi_r, pat1_lo_r};
    assign pat2_word = {pat2_hi_r, pat2_lo_r};
    assign pat_word = pat_sel_r ? pat2_word : pat1_word;

    always_comb begin
        // format select; codes 10 and 11 fall back to offset binary
        case (data_format_r[SOCR_FMT_MSB:SOCR_FMT_LSB])
            SOCR_FMT_TWOS_COMP: fmt_word = twos_word;
            default: fmt_word = SAMPLE_DATA;
        endcase
    end

    // user pattern substitution; the top 14 of 16 bits go out
    always_comb begin
        if (user_mode) begin
            sel_word = pat_word[SOCR_PAT_W-1 -: SOCR_DATA_W];
        end else begin
            sel_word = fmt_word;
        end
    end

    // output inversion after pattern selection, one gate per bit
    for (genvar b = 0; b < SOCR_DATA_W; b++) begin : g_invert
        assign word_nxt[b] = sel_word[b] ^ invert_on;
    end

    // patterns alternate word by word, from pattern one on entry
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pat_sel_r <= 1'b0;
        end else if (!user_mode) begin
            pat_sel_r <= 1'b0;
        end else if (SAMPLE_VALID) begin
            pat_sel_r <= ~pat_sel_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers

    // sample strobe delayed one cycle, whatever the phase code
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            OUT_VALID <= 1'b0;
        end else begin
            OUT_VALID <= SAMPLE_VALID;
        end
    end

    // word held between samples; latching ignores the phase code
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            OUT_WORD <= '0;
        end else if (SAMPLE_VALID) begin
            OUT_WORD <= word_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link settings
    // Registered so the pads only ever see settled values

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            OUT_LOW_SWING <= 1'b0;
        end else begin
            OUT_LOW_SWING <= data_format_r[SOCR_LOWSWING_BIT];
        end
    end

    // Termination setting to the drivers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            OUT_TERM <= 2'h0;
        end else begin
            OUT_TERM <= drv_term_r[SOCR_TERM_MSB:SOCR_TERM_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output clock phase select
    // Phases 0..5 are 60 degree taps; codes 6..10 wrap a full bit later

    logic [3:0] phase_code;
    logic phase_legal;
    logic phase_wrapped;
    logic [2:0] wrap_idx;
    logic [2:0] tap_idx;
    logic [5:0] tap_hot;

    assign phase_code = clk_phase_r[3:0];
    // Codes above 10 are undefined; they fall back to the reset phase
    assign phase_legal = (phase_code <= SOCR_PHASE_MAX);
    assign phase_wrapped = (phase_code >= 4'h6);
    // One bit period later than the same tap below code 6
    assign wrap_idx = 3'(phase_code - 4'h6);

    always_comb begin
        // 60 degree steps; code 9 is 540 = tap 3 plus one bit
        if (!phase_legal) begin
            tap_idx = SOCR_RST_CLK_PHASE[2:0];
        end else if (phase_wrapped) begin
            tap_idx = wrap_idx;
        end else begin
            tap_idx = phase_code[2:0];
        end
    end

    // one gate per divider phase; only the chosen tap passes
    for (genvar t = 0; t < 6; t++) begin : g_tap
        assign tap_hot[t] = (tap_idx == 3'(t)) && DIV_PHASES[t];
    end

    // A code change may clip one clock pulse; change it while the link is idle
    assign SERIAL_BIT_CLOCK_OUT = |tap_hot;

endmodule : socr_output_config

/* socr_assertions.sv */
// Port checks for the output configuration bank
`timescale 1ns/1ps
module socr_assertions (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic SAMPLE_VALID,
    input wire logic [5:0] DIV_PHASES,
    input wire logic [13:0] OUT_WORD,
    input wire logic OUT_VALID,
    input wire logic OUT_LOW_SWING,
    input wire logic SERIAL_BIT_CLOCK_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////
    a_valid_delay: assert property (SAMPLE_VALID |=> OUT_VALID)
        else $error("valid lost");
    a_word_hold: assert property (!$past(SAMPLE_VALID) |-> $stable(OUT_WORD))
        else $error("word moved");
    a_fmt_bits: assert property (REG_ADDR == 8'h14 |-> (REG_RDATA & 8'hB8) == 8'h00)
        else $error("format spare bits");
    a_pat_write: assert property (REG_WR && REG_ADDR == 8'h19 ##1 REG_ADDR == 8'h19
        |-> REG_RDATA == $past(REG_WDATA))
        else $error("pattern write");
    a_tap_low: assert property (REG_ADDR == 8'h16 && REG_RDATA < 8'h06
        |-> SERIAL_BIT_CLOCK_OUT == DIV_PHASES[REG_RDATA[2:0]])
        else $error("low tap");
    a_tap_high: assert property (REG_ADDR == 8'h16 && REG_RDATA inside {[8'h06:8'h0A]}
        |-> SERIAL_BIT_CLOCK_OUT == DIV_PHASES[REG_RDATA[2:0] - 3'd6])
        else $error("high tap");
    a_phase_bits: assert property (REG_ADDR == 8'h16 |-> REG_RDATA[7:4] == 4'h0)
        else $error("phase spare bits");
    a_unmapped: assert property (REG_ADDR == 8'h30 |-> REG_RDATA == 8'h00)
        else $error("unmapped read");
    a_swing_copy: assert property (REG_ADDR == 8'h14 ##1 REG_ADDR == 8'h14
        |-> OUT_LOW_SWING == $past(REG_RDATA[6]))
        else $error("swing copy");
    c_sample: cover property (SAMPLE_VALID);
    c_write: cover property (REG_WR);
    c_swing: cover property (OUT_LOW_SWING);
endmodule : socr_assertions

/* socr_div_model.sv */
// Clock divider model feeding six phase taps
`timescale 1ns/1ps
module socr_div_model (
    input wire logic CLK,
    input wire logic RSTN,
    output logic [5:0] DIV_PHASES
);
    // Rotating pattern, repeating every six cycles, so every tap differs over six cycles
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DIV_PHASES <= 6'h0B;
        end else begin
            DIV_PHASES <= {DIV_PHASES[4:0], DIV_PHASES[5]};
        end
    end
endmodule : socr_div_model

/* socr_output_config_test.sv */
// Self-checking bench for the output configuration bank
`timescale 1ns/1ps
module socr_output_config_test;
    logic CLK = 0, RSTN = 0, REG_WR = 0, SAMPLE_VALID = 0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
    logic [13:0] SAMPLE_DATA = 14'h0000, OUT_WORD;
    logic [5:0] DIV_PHASES;
    logic OUT_VALID, OUT_LOW_SWING, SERIAL_BIT_CLOCK_OUT;
    logic [1:0] OUT_TERM;
    int n_mismatch = 0, checked = 0;
    logic [7:0] adr [7] = '{8'h14, 8'h15, 8'h16, 8'h19, 8'h1A, 8'h1B, 8'h1C};
    logic [7:0] msk [7] = '{8'h47, 8'h30, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    always #12.5 CLK = ~CLK;
    socr_output_config uut (.CLK, .RSTN, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA, .SAMPLE_VALID,
        .SAMPLE_DATA, .DIV_PHASES, .OUT_WORD, .OUT_VALID, .OUT_LOW_SWING, .OUT_TERM, .SERIAL_BIT_CLOCK_OUT);
    socr_div_model div (.CLK, .RSTN, .DIV_PHASES);
    ////////////////////////////////////////////////////////////////
    task chk(input logic [13:0] seen, input logic [13:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK);
        REG_ADDR <= a;
        #1 chk(REG_RDATA, e, "rdata");
    endtask : rd
    task smp(input logic [13:0] d);
        @(posedge CLK);
        SAMPLE_VALID <= 1'b1;
        SAMPLE_DATA <= d;
        @(posedge CLK);
        SAMPLE_VALID <= 1'b0;
        #1;
    endtask : smp
    task end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        for (int i = 0; i < 7; i++) rd(adr[i], i == 2 ? 8'h03 : 8'h00);
        rd(8'h0D, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 7; i++) begin
            wr(adr[i], 8'hFF);
            rd(adr[i], msk[i]);
        end
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        $display("mask test done");
        for (int c = 0; c < 12; c++) begin
            wr(8'h16, 8'(c));
            repeat (6) begin
                @(negedge CLK);
                chk(SERIAL_BIT_CLOCK_OUT, DIV_PHASES[c < 6 ? c : (c < 11 ? c - 6 : 3)], "tap");
            end
        end
        $display("phase test done");
        wr(8'h14, 8'h00);
        smp(14'h2005);
        chk(OUT_WORD, 14'h2005, "offset");
        chk(OUT_VALID, 1'b1, "valid");
        wr(8'h14, 8'h01);
        smp(14'h2005);
        chk(OUT_WORD, 14'h0005, "twos");
        wr(8'h14, 8'h44);
        smp(14'h2005);
        chk(OUT_WORD, 14'h1FFA, "invert");
        chk(OUT_LOW_SWING, 1'b1, "swing");
        chk(OUT_TERM, 2'h3, "term");
        $display("format test done");
        wr(8'h14, 8'h00);
        wr(8'h19, 8'h34);
        wr(8'h1A, 8'h12);
        wr(8'h1B, 8'h78);
        wr(8'h1C, 8'h56);
        wr(8'h0D, 8'h08);
        rd(8'h0D, 8'h08);
        smp(14'h0000);
        chk(OUT_WORD, 14'h048D, "pattern one");
        smp(14'h0000);
        chk(OUT_WORD, 14'h159E, "pattern two");
        $display("pattern test done");
        end_of_test;
    end
endmodule : socr_output_config_test
bind socr_output_config socr_assertions chk_i (.CLK, .RSTN, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .SAMPLE_VALID, .DIV_PHASES, .OUT_WORD, .OUT_VALID, .OUT_LOW_SWING, .SERIAL_BIT_CLOCK_OUT);
